// *** design/counter_channel.sv ***
/*
  Gated 32-bit up/down counter channel with filtered inputs, comparator and
  event pulse, reached over an AHB-Lite slave port.
  Assumes one clock hclk at 50 MHz, asynchronous active-low hresetn, and
  encoder pins that are asynchronous to hclk.
*/
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
// Notes on behaviour
// R1: Up direction counts to limit minus one, then reloads load value on next up pulse.
// R2: Down direction counts to one, then reloads start value on next down pulse.
// R3: No main direction leaves range free; default is no main direction.
// R4: One limit acts as end or start value, default and maximum 2147483647.
// R5: Cancel gate mode restarts from load value at every gate opening; code uses the limit in down direction when load value is 0.
// R6: Stop gate mode pauses at closing and resumes from held value.
// R7: Count is compared with a programmable value, default zero.
// R8: Hysteresis 0 to 255 damps output; 0 or 1 switch it off.
// R9: Track and hardware gate inputs filtered to 10, 5, 2 or 1 kHz.
// R10: Latch input has its own filter step, default 10 kHz.
// R11: Evaluation is pulse/direction or encoder single, double or quadruple.
// R12: With hardware gate enabled, both gates must be open to count.
// R13: Direction inversion flips the direction track before use.
// R14: Output and reached flag follow the chosen output characteristic.
// R15: Pulse length is the even setting 0 to 510 times 1.024 ms.
// R16: Optional event when hardware gate opens with software gate open.
// R17: Optional event when hardware gate closes with software gate open.
// R18: Optional event on reaching compare value, only with a comparison mode.
// R19: Optional event on count overflow past the upper limit.
// R20: Optional event on count underflow below the lower limit.
// R21: In threshold modes output holds exactly while the condition holds; code clears it only beyond the hysteresis band when it is above 1.
// R22: Count is 32-bit two's complement; configuration changes only while idle.
`timescale 1ns/1ps
`include "counter_defines.svh"

module counter_channel
  import counter_pkg::*;
#(
  parameter int FILT10_CYC = `NS2CYC(`FILT_10K_NS),
  parameter int FILT5_CYC  = `NS2CYC(`FILT_5K_NS),
  parameter int FILT2_CYC  = `NS2CYC(`FILT_2K_NS),
  parameter int FILT1_CYC  = `NS2CYC(`FILT_1K_NS),
  parameter int PULSE_CYC  = `NS2CYC(`PULSE_UNIT_NS)
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        track_a_in,
  input  wire logic        track_b_in,
  input  wire logic        hardware_gate_input,
  input  wire logic        latch_in,
  output logic             counter_out,
  output logic             comparator_reached_flag,
  output logic             count_irq
);

  localparam state_t RST_ST = '{default: '0, ctrl: `CTRL_RST, limit: `LIMIT_RST,
                                hready: 1'b1, bst: BUS_IDLE};

  state_t             st_ff;
  state_t             nxt_st;
  main_dir_t          mdir;
  eval_t              eval;
  outc_t              outc;
  logic               hwen;
  logic               dinv;
  logic               stop;
  logic [4:0]         ien;
  logic               a;
  logic               ap;
  logic               b;
  logic               bp;
  logic               ach;
  logic               bch;
  logic               up;
  logic               dn;
  logic               g;
  logic               gopen;
  logic               run;
  logic               hit;
  logic               ev_hwo;
  logic               ev_hwc;
  logic               ev_cmp;
  logic               ev_ovf;
  logic               ev_unf;
  logic [4:0]         ev_en;
  logic [31:0]        nc;
  logic [14:0]        lim;
  logic signed [32:0] c33;
  logic signed [32:0] k33;
  logic signed [32:0] h33;

  // Filter step to least stable time in cycles
  function automatic logic [14:0] filt_lim(input logic [1:0] sel);
    case (sel)
      2'h0:    filt_lim = 15'(FILT10_CYC);
      2'h1:    filt_lim = 15'(FILT5_CYC);
      2'h2:    filt_lim = 15'(FILT2_CYC);
      default: filt_lim = 15'(FILT1_CYC);
    endcase
  endfunction

  // Configuration fields
  assign mdir = main_dir_t'(st_ff.ctrl[`CTRL_MDIR +: 2]);
  assign eval = eval_t'(st_ff.ctrl[`CTRL_EVAL +: 2]);
  assign outc = outc_t'(st_ff.ctrl[`CTRL_OUTC +: 2]);
  assign hwen = st_ff.ctrl[`CTRL_HWEN];
  assign dinv = st_ff.ctrl[`CTRL_DINV];
  assign stop = st_ff.ctrl[`CTRL_STOP];
  assign ien  = st_ff.ctrl[`CTRL_IEN +: 5];

  // Outputs straight from the state register, except hresp, which is tied low
  assign hrdata                  = st_ff.hrdata;
  assign hreadyout               = st_ff.hready;
  assign hresp                   = 1'b0;
  assign counter_out             = st_ff.out;
  assign comparator_reached_flag = st_ff.sticky[0];
  assign count_irq               = st_ff.irq;

  // Next state of the whole channel
  always_comb begin
    nxt_st     = st_ff;
    nxt_st.irq = 1'b0;
    lim        = '0;
    // Two-stage sync, then accept a level only after it stays stable long enough
    nxt_st.s1     = {latch_in, hardware_gate_input, track_b_in, track_a_in};
    nxt_st.s2     = st_ff.s1;
    nxt_st.q_prev = st_ff.flt_q;
    for (int i = 0; i < 4; i++) begin
      lim = (i == 3) ? filt_lim(st_ff.ctrl[`CTRL_LSEL +: 2])    // [R10]
                     : filt_lim(st_ff.ctrl[`CTRL_FSEL +: 2]);   // [R9]
      if (st_ff.s2[i] == st_ff.flt_q[i]) begin
        nxt_st.fcnt[i] = '0;
      end else if (st_ff.fcnt[i] >= lim - 15'h1) begin
        nxt_st.flt_q[i] = st_ff.s2[i];
        nxt_st.fcnt[i]  = '0;
      end else begin
        nxt_st.fcnt[i] = st_ff.fcnt[i] + 15'h1;
      end
    end

    // Edge decode of the tracks
    a   = st_ff.flt_q[0];
    ap  = st_ff.q_prev[0];
    b   = st_ff.flt_q[1] ^ dinv;                                // [R13]
    bp  = st_ff.q_prev[1] ^ dinv;                               // [R13]
    ach = a ^ ap;
    bch = b ^ bp;
    case (eval)                                                 // [R11]
      EVAL_PDIR: begin
        up = a & ~ap & ~b;
        dn = a & ~ap & b;
      end
      EVAL_X1: begin
        up = a & ~ap & ~b;
        dn = ~a & ap & ~b;
      end
      EVAL_X2: begin
        up = ach & (a ^ b);
        dn = ach & ~(a ^ b);
      end
      default: begin
        up = (ach & ~bch & (a ^ b)) | (bch & ~ach & ~(a ^ b));
        dn = (ach & ~bch & ~(a ^ b)) | (bch & ~ach & (a ^ b));
      end
    endcase

    // Effective gate and hardware gate edges
    g           = st_ff.swg & (~hwen | st_ff.flt_q[2]);         // [R12]
    nxt_st.gate = g;
    gopen       = g & ~st_ff.gate;
    run         = g & st_ff.gate;
    ev_hwo      = hwen & st_ff.swg & st_ff.flt_q[2] & ~st_ff.q_prev[2];  // [R16]
    ev_hwc      = hwen & st_ff.swg & ~st_ff.flt_q[2] & st_ff.q_prev[2];  // [R17]

    // Counting with wrap limits, two's complement
    nc     = st_ff.cnt;
    ev_ovf = 1'b0;
    ev_unf = 1'b0;
    if (gopen && !stop) begin                                   // [R5]
      nc = (mdir == MDIR_DOWN && st_ff.load == 32'h0) ? st_ff.limit : st_ff.load;
    end else if (run && up) begin                               // [R6]
      nxt_st.dir_dn = 1'b0;
      if (mdir == MDIR_UP && $signed(st_ff.cnt) >= $signed(st_ff.limit) - 32'sh1) begin
        nc     = st_ff.load;                                    // [R1]
        ev_ovf = 1'b1;
      end else begin
        nc     = st_ff.cnt + 32'h1;                             // [R3] [R22]
        ev_ovf = (st_ff.cnt == 32'h7FFFFFFF);
      end
    end else if (run && dn) begin
      nxt_st.dir_dn = 1'b1;
      if (mdir == MDIR_DOWN && $signed(st_ff.cnt) <= 32'sh1) begin
        nc     = st_ff.limit;                                   // [R2] [R4]
        ev_unf = 1'b1;
      end else begin
        nc     = st_ff.cnt - 32'h1;
        ev_unf = (st_ff.cnt == 32'h80000000);
      end
    end
    nxt_st.cnt = nc;
    hit = run & (up | dn) & (nc == st_ff.cmpv) &
          ((mdir == MDIR_NONE) | ((mdir == MDIR_UP) & up) | ((mdir == MDIR_DOWN) & dn));

    // Latch capture on a filtered rising edge
    if (st_ff.flt_q[3] && !st_ff.q_prev[3]) begin
      nxt_st.latch = st_ff.cnt;
    end

    // Comparator with hysteresis band
    c33 = {st_ff.cnt[31], st_ff.cnt};                           // [R7]
    k33 = {st_ff.cmpv[31], st_ff.cmpv};
    h33 = (st_ff.hyst > 8'h01) ? {25'h0, st_ff.hyst} : 33'sh0;  // [R8]
    case (outc)                                                 // [R14]
      OUTC_GE: begin
        nxt_st.ptmr = '0;
        if (!st_ff.out && c33 >= k33) begin                     // [R21]
          nxt_st.out = 1'b1;
        end else if (st_ff.out && c33 < k33 - h33) begin
          nxt_st.out = 1'b0;
        end
      end
      OUTC_LE: begin
        nxt_st.ptmr = '0;
        if (!st_ff.out && c33 <= k33) begin                     // [R21]
          nxt_st.out = 1'b1;
        end else if (st_ff.out && c33 > k33 + h33) begin
          nxt_st.out = 1'b0;
        end
      end
      OUTC_PULSE: begin
        if (st_ff.plen == 9'h0) begin
          nxt_st.out  = (st_ff.cnt == st_ff.cmpv);
          nxt_st.ptmr = '0;
        end else if (hit) begin
          nxt_st.out  = 1'b1;
          nxt_st.ptmr = 25'(st_ff.plen * PULSE_CYC);            // [R15]
        end else if (st_ff.ptmr <= 25'h1) begin
          nxt_st.out  = 1'b0;
          nxt_st.ptmr = '0;
        end else begin
          nxt_st.ptmr = st_ff.ptmr - 25'h1;
        end
      end
      default: begin
        nxt_st.out  = st_ff.ctrl[`CTRL_MANOUT];
        nxt_st.ptmr = '0;
      end
    endcase
    ev_cmp = nxt_st.out & ~st_ff.out & (outc != OUTC_NONE);    // [R18]

    // AHB-Lite slave: address phase, one wait cycle, then data
    case (st_ff.bst)
      BUS_IDLE: begin
        nxt_st.hready = 1'b1;
        if (hsel && htrans[1] && hready) begin
          nxt_st.bst    = BUS_DATA;
          nxt_st.hready = 1'b0;
          nxt_st.dwr    = hwrite;
          nxt_st.didx   = haddr[7:2];
        end
      end
      BUS_DATA: begin
        nxt_st.bst    = BUS_IDLE;
        nxt_st.hready = 1'b1;
        if (st_ff.dwr) begin
          case ({st_ff.didx, 2'b00})
            `OFS_GATE:   nxt_st.swg = hwdata[0];
            `OFS_STATUS: nxt_st.sticky = st_ff.sticky & ~hwdata[`STAT_STICKY +: 8];
            default: begin
              // Setup only while the counter is idle
              if (!st_ff.gate) begin                            // [R22]
                case ({st_ff.didx, 2'b00})
                  `OFS_CTRL: nxt_st.ctrl = hwdata[`CTRL_W-1:0];
                  `OFS_LIMIT: begin
                    if (hwdata >= `LIMIT_MIN && !hwdata[31]) begin  // [R4]
                      nxt_st.limit = hwdata;
                    end
                  end
                  `OFS_LOAD: nxt_st.load = hwdata;
                  `OFS_CMPV: nxt_st.cmpv = hwdata;
                  `OFS_HYST: nxt_st.hyst = hwdata[7:0];
                  `OFS_PLEN: nxt_st.plen = {hwdata[8:1], 1'b0};     // [R15]
                  default: nxt_st.hyst = st_ff.hyst;
                endcase
              end
            end
          endcase
        end else begin
          case ({st_ff.didx, 2'b00})
            `OFS_CTRL:   nxt_st.hrdata = {13'h0, st_ff.ctrl};
            `OFS_LIMIT:  nxt_st.hrdata = st_ff.limit;
            `OFS_LOAD:   nxt_st.hrdata = st_ff.load;
            `OFS_CMPV:   nxt_st.hrdata = st_ff.cmpv;
            `OFS_HYST:   nxt_st.hrdata = {24'h0, st_ff.hyst};
            `OFS_PLEN:   nxt_st.hrdata = {23'h0, st_ff.plen};
            `OFS_COUNT:  nxt_st.hrdata = st_ff.cnt;
            `OFS_STATUS: nxt_st.hrdata = {19'h0, st_ff.sticky, st_ff.dir_dn, st_ff.out,
                                          st_ff.flt_q[3], st_ff.flt_q[2], st_ff.gate};
            `OFS_LATCH:  nxt_st.hrdata = st_ff.latch;
            `OFS_GATE:   nxt_st.hrdata = {31'h0, st_ff.swg};
            default:     nxt_st.hrdata = 32'h0;
          endcase
        end
      end
      default: begin
        nxt_st.bst    = BUS_IDLE;
        nxt_st.hready = 1'b1;
      end
    endcase

    // Sticky flags after the clear so a same-cycle event wins
    ev_en = ien & {ev_unf, ev_ovf, ev_cmp, ev_hwc, ev_hwo};    // [R16] [R17] [R19] [R20]
    nxt_st.sticky = nxt_st.sticky | {ev_en, ev_unf, ev_ovf, ev_cmp};
    nxt_st.irq    = |ev_en;
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= RST_ST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_UP_WRAP: assert property (run && up && !gopen && mdir == MDIR_UP &&  // [R1]
      $signed(st_ff.cnt) >= $signed(st_ff.limit) - 32'sh1 |=> st_ff.cnt == $past(st_ff.load))
    else $error("up wrap did not reload");
  AST_DN_WRAP: assert property (run && dn && !up && mdir == MDIR_DOWN &&   // [R2]
      $signed(st_ff.cnt) <= 32'sh1 |=> st_ff.cnt == $past(st_ff.limit) && st_ff.sticky[2])
    else $error("down wrap did not reload start value");
  AST_CANCEL: assert property (gopen && !stop && mdir != MDIR_DOWN         // [R5]
      |=> st_ff.cnt == $past(st_ff.load))
    else $error("gate opening did not restart from load");
  AST_STOP_HOLD: assert property (!st_ff.gate && (stop || !g) |=> $stable(st_ff.cnt))  // [R6]
    else $error("count moved while gate closed");
  AST_HARDWARE_GATE_INPUT: assert property (st_ff.gate && hwen |-> $past(st_ff.flt_q[2]))  // [R12]
    else $error("counting with hardware gate closed");
  AST_GE_OUT: assert property (outc == OUTC_GE && st_ff.hyst < 8'h02        // [R21]
      |=> st_ff.out == ($signed($past(st_ff.cnt)) >= $signed($past(st_ff.cmpv))))
    else $error("threshold output wrong");
  AST_PULSE_LEN: assert property (outc == OUTC_PULSE && hit && st_ff.plen != 9'h0  // [R15]
      |=> st_ff.out && st_ff.ptmr == 25'($past(st_ff.plen) * PULSE_CYC))
    else $error("pulse timer not loaded");
  AST_OVF_IRQ: assert property (ev_ovf && ien[3] |=> count_irq && st_ff.sticky[6])  // [R19]
    else $error("overflow event missing");
  AST_UNF_FLAG: assert property (ev_unf |=> st_ff.sticky[2])               // [R20]
    else $error("underflow flag missing");
  AST_FILT: assert property ($changed(st_ff.flt_q[0]) |->                   // [R9]
      $past(st_ff.fcnt[0]) == filt_lim($past(st_ff.ctrl[`CTRL_FSEL +: 2])) - 15'h1)
    else $error("filter accepted early");
  AST_BUS_WAIT: assert property (!st_ff.hready |=> st_ff.hready)
    else $error("wait state too long");

  COV_UP_WRAP: cover property (ev_ovf && mdir == MDIR_UP);
  COV_CMP:     cover property (ev_cmp ##1 count_irq);
  COV_GATE:    cover property (gopen ##[1:20] run && up);

endmodule

// *** design/counter_defines.svh ***
/*
  Offsets, field positions, reset values and timing figures of the counter channel.
  Assumes a 50 MHz hclk and byte addresses on an AHB-Lite slave port.
*/
`ifndef COUNTER_DEFINES_SVH
`define COUNTER_DEFINES_SVH

// Clock rate and conversion of a least time in ns to whole cycles
`define CLK_MHZ         50
`define NS2CYC(ns)      ((((ns) * `CLK_MHZ) + 999) / 1000)

// Least stable time of a filtered input, half the period of its top rate
`define FILT_10K_NS     50000
`define FILT_5K_NS      100000
`define FILT_2K_NS      250000
`define FILT_1K_NS      500000
// Unit of the compare pulse length, 1.024 ms
`define PULSE_UNIT_NS   1024000

// Register byte offsets
`define OFS_CTRL        8'h00
`define OFS_LIMIT       8'h04
`define OFS_LOAD        8'h08
`define OFS_CMPV        8'h0C
`define OFS_HYST        8'h10
`define OFS_PLEN        8'h14
`define OFS_COUNT       8'h18
`define OFS_STATUS      8'h1C
`define OFS_LATCH       8'h20
`define OFS_GATE        8'h24

// Control field positions
`define CTRL_W          19
`define CTRL_HWEN       0
`define CTRL_DINV       1
`define CTRL_MDIR       2
`define CTRL_STOP       4
`define CTRL_EVAL       5
`define CTRL_FSEL       7
`define CTRL_LSEL       9
`define CTRL_OUTC       11
`define CTRL_IEN        13
`define CTRL_MANOUT     18

// Status: sticky field starts here, write one to clear
`define STAT_STICKY     5

// Reset values
`define CTRL_RST        19'h00000
`define LIMIT_RST       32'h7FFFFFFF
`define LIMIT_MIN       32'h00000002

`endif

// *** design/counter_pkg.sv ***
/*
  Types of the counter channel: configuration encodings, bus states, state record.
  Assumes counter_defines.svh for the numeric constants.
*/
package counter_pkg;

  typedef enum logic [1:0] {MDIR_NONE = 2'h0, MDIR_UP = 2'h1, MDIR_DOWN = 2'h2} main_dir_t;
  typedef enum logic [1:0] {EVAL_PDIR = 2'h0, EVAL_X1 = 2'h1, EVAL_X2 = 2'h2,
                            EVAL_X4 = 2'h3} eval_t;
  typedef enum logic [1:0] {OUTC_NONE = 2'h0, OUTC_GE = 2'h1, OUTC_LE = 2'h2,
                            OUTC_PULSE = 2'h3} outc_t;
  typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_DATA = 2'b10} bus_state_t;

  // Whole state of one channel
  typedef struct packed {
    logic [3:0]       s1;
    logic [3:0]       s2;
    logic [3:0]       flt_q;
    logic [3:0]       q_prev;
    logic [3:0][14:0] fcnt;
    logic             gate;
    logic [31:0]      cnt;
    logic [31:0]      latch;
    logic             out;
    logic             dir_dn;
    logic [24:0]      ptmr;
    logic [18:0]      ctrl;
    logic [31:0]      limit;
    logic [31:0]      load;
    logic [31:0]      cmpv;
    logic [7:0]       hyst;
    logic [8:0]       plen;
    logic             swg;
    logic [7:0]       sticky;
    bus_state_t       bst;
    logic             dwr;
    logic [5:0]       didx;
    logic [31:0]      hrdata;
    logic             hready;
    logic             irq;
  } state_t;

endpackage

// *** dv/encoder_model.sv ***
/*
  Pulse/direction and quadrature source driving the counter track pins.
  Assumes its tasks are called just after a rising hclk edge.
*/
`timescale 1ns/1ps
module encoder_model (
  input  wire logic hclk,
  output logic      track_a_in,
  output logic      track_b_in
);
  logic [1:0] ph;

  // Pins start low, quadrature phase zero
  initial begin
    track_a_in = 1'b0;
    track_b_in = 1'b0;
    ph = 2'h0;
  end

  // Direction first, then one pulse; each level stands hold cycles
  task automatic pulse(input logic dn, input int hold);
    track_b_in <= dn;
    repeat (hold) @(posedge hclk);
    track_a_in <= 1'b1;
    repeat (hold) @(posedge hclk);
    track_a_in <= 1'b0;
    repeat (hold) @(posedge hclk);
  endtask

  // One quarter step along the Gray sequence 00, 01, 11, 10
  task automatic quad(input logic fwd, input int hold);
    ph = fwd ? ph + 2'h1 : ph - 2'h1;
    {track_a_in, track_b_in} <= {ph[1], ph[1] ^ ph[0]};
    repeat (hold) @(posedge hclk);
  endtask
endmodule

// *** dv/test_gated_updown_counter_config.sv ***
/*
  Self-checking bench of the counter channel with an integer count model.
  Assumes encoder_model on the track pins and shortened filter parameters.
*/
`timescale 1ns/1ps
`include "counter_defines.svh"
module test_gated_updown_counter_config;
  import counter_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hwgate, latch_in;
  logic        hreadyout, hresp, ta, tb, c_out, c_flag, c_irq, inv, h;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          err_total, checks_done, seed, m, irq_n, irq0, hi_n, mdir, lim, ld, hy;
  int          oc[3] = '{1, 2, 1};
  int          cv[3] = '{2, 2, 4};
  int          hv[3] = '{0, 1, 3};

  // Clock
  initial hclk = 1'b0;
  always #10 hclk = ~hclk;

  counter_channel #(.FILT10_CYC(4), .FILT5_CYC(5), .FILT2_CYC(6), .FILT1_CYC(7),
    .PULSE_CYC(8)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .track_a_in(ta), .track_b_in(tb), .hardware_gate_input(hwgate),
    .latch_in(latch_in), .counter_out(c_out), .comparator_reached_flag(c_flag),
    .count_irq(c_irq));
  encoder_model enc (.hclk(hclk), .track_a_in(ta), .track_b_in(tb));

  // Count event pulses and output high cycles
  always @(posedge hclk) begin
    if (c_irq === 1'b1) irq_n++;
    if (c_out === 1'b1) hi_n++;
  end

  // Verdict and end of run
  task automatic summarize;
    if (err_total == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Compare and report
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Wait for hready sampled high, bounded
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) cmp(32'h1, 32'h0);
  endtask

  // Single word transfer; read data land in rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    rdy();
    rd = hrdata;
    cmp(32'(hresp), 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(rd, e);
  endtask

  // Close gate, program, reopen; cancel mode starts from load, or from limit in down mode with load 0
  task automatic cfg(input logic [18:0] c, input logic [31:0] l, input logic [31:0] d);
    wr(`OFS_GATE, 32'h0);
    wr(`OFS_CTRL, {13'h0, c});
    wr(`OFS_LIMIT, l);
    wr(`OFS_LOAD, d);
    mdir = c[3:2];
    inv = c[1];
    lim = l;
    ld = d;
    wr(`OFS_GATE, 32'h1);
    // Stop mode, or a closed hardware gate, keeps the held count
    if (!c[4] && !(c[0] && !hwgate)) m = (mdir == 2 && d == 0) ? l : d;
  endtask

  // One pulse on the pins and the model step
  task automatic st(input logic dn);
    enc.pulse(dn ^ inv, 14);
    if (mdir == 1) m = (m >= lim - 1) ? ld : m + 1;
    else if (mdir == 2) m = (m <= 1) ? lim : m - 1;
    else m = dn ? m - 1 : m + 1;
  endtask

  // Hang guard
  initial begin
    repeat (60000) @(posedge hclk);
    err_total++;
    summarize();
  end

  // Main sequence
  initial begin
    {hresetn, hsel, hwrite, hwgate, latch_in, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    {err_total, checks_done, irq_n, hi_n, m, mdir} = '0;
    seed = 39;
    inv = 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    chk(`OFS_CTRL, 32'h0);
    chk(`OFS_LIMIT, 32'h7FFFFFFF);
    chk(`OFS_CMPV, 32'h0);
    chk(8'h3C, 32'h0);
    wr(`OFS_LIMIT, 32'h80000000);
    chk(`OFS_LIMIT, 32'h7FFFFFFF);
    // Encoder evaluations: one turn forward, one back
    for (int e = 1; e < 4; e++) begin
      cfg(19'(e << 5), 32'h7FFFFFFF, 32'h0);
      repeat (4) enc.quad(1'b1, 14);
      bus(1'b0, `OFS_COUNT, 32'h0);
      cmp(($signed(rd) < 0) ? -rd : rd, 32'(1 << (e - 1)));
      repeat (4) enc.quad(1'b0, 14);
      chk(`OFS_COUNT, 32'h0);
    end
    // Free range, random directions, one short glitch
    cfg(19'h0, 32'h7FFFFFFF, 32'h0);
    st(1'b1);
    chk(`OFS_COUNT, m);
    for (int i = 0; i < 8; i++) st(1'($random(seed)));
    enc.pulse(1'b0, 3);
    chk(`OFS_COUNT, m);
    wr(`OFS_CTRL, 32'h4);
    chk(`OFS_CTRL, 32'h0);
    // Inverted direction, restart from load
    cfg(19'h2, 32'h7FFFFFFF, 32'h5);
    st(1'b0);
    st(1'b0);
    chk(`OFS_COUNT, m);
    // Stop mode holds the count across a closed gate
    cfg(19'h10, 32'h7FFFFFFF, 32'h0);
    st(1'b0);
    wr(`OFS_GATE, 32'h0);
    enc.pulse(1'b0, 14);
    wr(`OFS_GATE, 32'h1);
    st(1'b0);
    chk(`OFS_COUNT, m);
    // Up mode wraps to load with overflow event
    cfg(19'h10004, 32'h5, 32'h2);
    irq0 = irq_n;
    for (int i = 0; i < 3; i++) begin
      st(1'b0);
      chk(`OFS_COUNT, m);
    end
    cmp(irq_n - irq0, 32'h1);
    // Free range underflow from the most negative value
    cfg(19'h20000, 32'h7FFFFFFF, 32'h80000000);
    irq0 = irq_n;
    st(1'b1);
    chk(`OFS_COUNT, m);
    cmp(irq_n - irq0, 32'h1);
    // Down mode reloads the start value after one
    cfg(19'h8, 32'h3, 32'h0);
    for (int i = 0; i < 3; i++) begin
      st(1'b1);
      chk(`OFS_COUNT, m);
    end
    // Threshold modes with and without hysteresis
    for (int t = 0; t < 3; t++) begin
      wr(`OFS_GATE, 32'h0);
      wr(`OFS_STATUS, 32'h20);
      wr(`OFS_CMPV, cv[t]);
      wr(`OFS_HYST, hv[t]);
      cfg(19'(oc[t] << 11) | 19'h08000, 32'h7FFFFFFF, 32'h0);
      irq0 = irq_n;
      h = 1'b0;
      hy = (hv[t] > 1) ? hv[t] : 0;
      for (int k = 0; k < 8; k++) begin
        st(k >= 4);
        if (oc[t] == 1) h = (m >= cv[t]) ? 1'b1 : (m < cv[t] - hy) ? 1'b0 : h;
        else h = (m <= cv[t]) ? 1'b1 : (m > cv[t] + hy) ? 1'b0 : h;
        cmp(32'(c_out), 32'(h));
      end
      cmp(32'(c_flag), 32'h1);
      cmp(32'(irq_n > irq0), 32'h1);
    end
    // Timed pulse on reaching the compare value
    wr(`OFS_GATE, 32'h0);
    wr(`OFS_CMPV, 32'h2);
    wr(`OFS_PLEN, 32'h3);
    chk(`OFS_PLEN, 32'h2);
    cfg(19'h1804, 32'h7FFFFFFF, 32'h0);
    hi_n = 0;
    st(1'b0);
    st(1'b0);
    repeat (30) @(posedge hclk);
    cmp(hi_n, 32'd16);
    // Hardware gate with open and close events, manual output in no-compare mode
    cfg(19'h46001, 32'h7FFFFFFF, 32'h0);
    irq0 = irq_n;
    enc.pulse(1'b0, 14);
    chk(`OFS_COUNT, m);
    cmp(32'(c_out), 32'h1);
    hwgate <= 1'b1;
    repeat (14) @(posedge hclk);
    m = ld;
    st(1'b0);
    chk(`OFS_COUNT, m);
    hwgate <= 1'b0;
    repeat (14) @(posedge hclk);
    cmp(irq_n - irq0, 32'h2);
    // Latch capture with the slowest latch filter
    cfg(19'h680, 32'h7FFFFFFF, 32'h0);
    st(1'b0);
    st(1'b0);
    // Short latch pulse passes the track step but not the latch step
    latch_in <= 1'b1;
    repeat (5) @(posedge hclk);
    latch_in <= 1'b0;
    repeat (14) @(posedge hclk);
    chk(`OFS_LATCH, 32'h0);
    latch_in <= 1'b1;
    repeat (14) @(posedge hclk);
    latch_in <= 1'b0;
    repeat (14) @(posedge hclk);
    chk(`OFS_LATCH, m);
    summarize();
  end
endmodule
